/* File: logic/fluntp_regs.svh */
`ifndef FLUNTP_REGS_SVH
`define FLUNTP_REGS_SVH
// Control register value that starts the unlock sequence
`define FLUNTP_CTRL_RESET_VAL   8'h00
// Reset value of the frequency bytes
`define FLUNTP_FREQ_RESET       8'h00
// Divider from kHz value to a 1 kHz tick: clock cycles per ms = khz
`define FLUNTP_KHZ_PER_MHZ      16'h03e8
// Supported clock window, in kHz
`define FLUNTP_KHZ_MIN          16'h0014
`define FLUNTP_KHZ_MAX          16'h4e20
// Default key values written to the control register after page select
`define FLUNTP_KEY1_DEFAULT     8'h73
`define FLUNTP_KEY2_DEFAULT     8'h8c
// Default operation length in 1 kHz ticks
`define FLUNTP_OP_TICKS_DEFAULT 16'h0002
`endif

/* File: logic/fluntp_pkg.sv */
package fluntp_pkg;
    typedef enum logic [2:0]
    {
        lock_idle,
        lock_got_reset,
        lock_got_page,
        lock_got_key1,
        lock_open
    } fluntp_lock_t;

    typedef enum logic [1:0]
    {
        op_idle,
        op_busy
    } fluntp_op_t;
endpackage : fluntp_pkg

/* File: logic/fluntp_tick.sv */
`timescale 1ns/1ps
`include "fluntp_regs.svh"
// Produces a one-cycle pulse every flash_clock_khz cycles (one per ms)
module fluntp_tick
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        reset,
    // Control
    input  wire logic        run,
    input  wire logic [15:0] flash_clock_khz,
    // Output
    output logic             tick
);
    logic [15:0] count;
    logic [15:0] next_count;
    logic        next_tick;

    always_comb
    begin
        next_count = count;
        next_tick  = 1'b0;
        if (!run)
        begin
            next_count = 16'h0000;
        end
        else if (count + 16'h0001 >= flash_clock_khz)
        begin
            next_count = 16'h0000;
            next_tick  = 1'b1;
        end
        else
        begin
            next_count = count + 16'h0001;
        end
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            count <= 16'h0000;
            tick  <= 1'b0;
        end
        else
        begin
            count <= next_count;
            tick  <= next_tick;
        end
    end
endmodule : fluntp_tick

/* File: logic/fluntp_top.sv */
`timescale 1ns/1ps
`include "fluntp_regs.svh"
// Operation
// - Frequency high and low bytes form a 16-bit kHz value timing program and erase.
// - Any reset leaves the controller locked, blocking programming and erasure.
// - Program or erase is allowed only after the unlock write sequence.
// - Out-of-sequence control or page select writes relock the controller.
// - First step writes 00 to control register, resetting controller state.
// - Read protect option blocks debugger and bypass reads of user code.
// - Write or erase needs unlock, sector protection and write-protect option agreeing.
module fluntp_top
#(
    parameter logic [7:0]  KEY1      = `FLUNTP_KEY1_DEFAULT,
    parameter logic [7:0]  KEY2      = `FLUNTP_KEY2_DEFAULT,
    parameter logic [15:0] OP_TICKS  = `FLUNTP_OP_TICKS_DEFAULT,
    parameter int          PAGE_BITS = 7
)
(
    // Clock and reset
    input  wire logic                 clock,
    input  wire logic                 reset,
    // Register writes from the CPU
    input  wire logic                 ctrl_write,
    input  wire logic                 page_write,
    input  wire logic                 freq_high_write,
    input  wire logic                 freq_low_write,
    input  wire logic [7:0]           write_data,
    // Protection inputs
    input  wire logic [7:0]           sector_protect,
    input  wire logic                 write_protect_option,
    input  wire logic                 read_protect_option,
    // Operation requests
    input  wire logic                 program_request,
    input  wire logic                 erase_request,
    // Read requests
    input  wire logic                 debug_read_request,
    input  wire logic                 bypass_read_request,
    input  wire logic                 cpu_read_request,
    // Flash array side
    output logic                      flash_program,
    output logic                      flash_erase,
    output logic [PAGE_BITS-1:0]      flash_page,
    output logic                      flash_read,
    // Status
    output logic                      unlocked,
    output logic                      busy,
    output logic                      read_blocked,
    output logic                      request_refused,
    output logic                      freq_out_of_range,
    output logic [15:0]               flash_clock_khz
);
    //////////////////////////////////////////////////////////////////////////
    fluntp_pkg::fluntp_lock_t lock_state;
    fluntp_pkg::fluntp_lock_t next_lock_state;
    fluntp_pkg::fluntp_op_t   op_state;
    fluntp_pkg::fluntp_op_t   next_op_state;
    logic [15:0]              next_flash_clock_khz;
    logic [PAGE_BITS-1:0]     page;
    logic [PAGE_BITS-1:0]     next_page;
    logic [15:0]              op_count;
    logic [15:0]              next_op_count;
    logic                     next_flash_program;
    logic                     next_flash_erase;
    logic                     next_flash_read;
    logic                     next_read_blocked;
    logic                     next_refused;
    logic                     next_range;
    logic                     sector_ok;
    logic                     allowed;
    logic                     tick;

    // Sector is one eighth of the page space
    assign sector_ok = !sector_protect[page[PAGE_BITS-1 -: 3]];
    assign allowed   = (lock_state == fluntp_pkg::lock_open) && sector_ok
                       && !write_protect_option;

    //////////////////////////////////////////////////////////////////////////
    // Frequency value
    always_comb
    begin
        next_flash_clock_khz = flash_clock_khz;
        if (freq_high_write)
        begin
            next_flash_clock_khz[15:8] = write_data;
        end
        if (freq_low_write)
        begin
            next_flash_clock_khz[7:0] = write_data;
        end
        next_range = (flash_clock_khz < `FLUNTP_KHZ_MIN)
                     || (flash_clock_khz > `FLUNTP_KHZ_MAX);
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            flash_clock_khz   <= {`FLUNTP_FREQ_RESET, `FLUNTP_FREQ_RESET};
            freq_out_of_range <= 1'b1;
        end
        else
        begin
            flash_clock_khz   <= next_flash_clock_khz;
            freq_out_of_range <= next_range;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Unlock sequence
    always_comb
    begin
        next_lock_state = lock_state;
        next_page       = page;
        if (ctrl_write)
        begin
            if (write_data == `FLUNTP_CTRL_RESET_VAL)
            begin
                next_lock_state = fluntp_pkg::lock_got_reset;
            end
            else
            begin
                case (lock_state)
                    fluntp_pkg::lock_got_page:
                        next_lock_state = (write_data == KEY1) ? fluntp_pkg::lock_got_key1
                                          : fluntp_pkg::lock_idle;
                    fluntp_pkg::lock_got_key1:
                        next_lock_state = (write_data == KEY2) ? fluntp_pkg::lock_open
                                          : fluntp_pkg::lock_idle;
                    default:
                        next_lock_state = fluntp_pkg::lock_idle;
                endcase
            end
        end
        else if (page_write)
        begin
            next_page = write_data[PAGE_BITS-1:0];
            next_lock_state = (lock_state == fluntp_pkg::lock_got_reset)
                              ? fluntp_pkg::lock_got_page
                              : fluntp_pkg::lock_idle;
        end
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            lock_state <= fluntp_pkg::lock_idle;
            page       <= '0;
            unlocked   <= 1'b0;
        end
        else
        begin
            lock_state <= next_lock_state;
            page       <= next_page;
            unlocked   <= (next_lock_state == fluntp_pkg::lock_open);
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Program and erase timing
    fluntp_tick u_tick
    (
        .clock           (clock),
        .reset           (reset),
        .run             (op_state == fluntp_pkg::op_busy),
        .flash_clock_khz (flash_clock_khz),
        .tick            (tick)
    );

    always_comb
    begin
        next_op_state      = op_state;
        next_op_count      = op_count;
        next_flash_program = flash_program;
        next_flash_erase   = flash_erase;
        next_refused       = 1'b0;
        case (op_state)
            fluntp_pkg::op_idle:
            begin
                if (program_request || erase_request)
                begin
                    if (allowed && !freq_out_of_range)
                    begin
                        next_op_state      = fluntp_pkg::op_busy;
                        next_op_count      = OP_TICKS;
                        next_flash_program = program_request;
                        next_flash_erase   = erase_request && !program_request;
                    end
                    else
                    begin
                        next_refused = 1'b1;
                    end
                end
            end
            fluntp_pkg::op_busy:
            begin
                if (tick)
                begin
                    next_op_count = op_count - 16'h0001;
                    if (op_count <= 16'h0001)
                    begin
                        next_op_state      = fluntp_pkg::op_idle;
                        next_flash_program = 1'b0;
                        next_flash_erase   = 1'b0;
                    end
                end
            end
            default:
                next_op_state = fluntp_pkg::op_idle;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            op_state        <= fluntp_pkg::op_idle;
            op_count        <= 16'h0000;
            flash_program   <= 1'b0;
            flash_erase     <= 1'b0;
            busy            <= 1'b0;
            request_refused <= 1'b0;
        end
        else
        begin
            op_state        <= next_op_state;
            op_count        <= next_op_count;
            flash_program   <= next_flash_program;
            flash_erase     <= next_flash_erase;
            busy            <= (next_op_state == fluntp_pkg::op_busy);
            request_refused <= next_refused;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Read protection
    always_comb
    begin
        next_read_blocked = read_protect_option
                            && (debug_read_request || bypass_read_request);
        next_flash_read   = cpu_read_request
                            || (!read_protect_option
                                && (debug_read_request || bypass_read_request));
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            flash_read   <= 1'b0;
            read_blocked <= 1'b0;
            flash_page   <= '0;
        end
        else
        begin
            flash_read   <= next_flash_read;
            read_blocked <= next_read_blocked;
            flash_page   <= page;
        end
    end
endmodule : fluntp_top

/* File: tb/fluntp_flash_model.sv */
`timescale 1ns/1ps
module fluntp_flash_model
#(
    parameter int PAGE_BITS = 7
)
(
    // Array control
    input  wire logic                 clock,
    input  wire logic                 flash_program,
    input  wire logic                 flash_erase,
    input  wire logic [PAGE_BITS-1:0] flash_page,
    // Activity record
    output logic [7:0]                writes,
    output logic [PAGE_BITS-1:0]      last_page
);
    logic prog_q;
    logic erase_q;
    initial writes = 8'h00;
////////////////////////////////////////
    // Each start of a program or erase alters the array
    always @(posedge clock)
    begin
        prog_q <= flash_program;
        erase_q <= flash_erase;
        if ((flash_program && !prog_q) || (flash_erase && !erase_q))
        begin
            writes <= writes + 8'h01;
            last_page <= flash_page;
        end
    end
endmodule : fluntp_flash_model

/* File: tb/fluntp_props.sv */
`timescale 1ns/1ps
module fluntp_props
#(
    parameter int PAGE_BITS = 7
)
(
    // Clock, reset and writes
    input wire logic                 clock,
    input wire logic                 reset,
    input wire logic                 ctrl_write,
    input wire logic                 page_write,
    input wire logic                 freq_high_write,
    input wire logic [7:0]           write_data,
    // Protection and requests
    input wire logic [7:0]           sector_protect,
    input wire logic                 write_protect_option,
    input wire logic                 read_protect_option,
    input wire logic                 program_request,
    input wire logic                 erase_request,
    input wire logic                 debug_read_request,
    input wire logic                 cpu_read_request,
    // Outputs
    input wire logic                 flash_program,
    input wire logic                 flash_erase,
    input wire logic [PAGE_BITS-1:0] flash_page,
    input wire logic                 flash_read,
    input wire logic                 unlocked,
    input wire logic                 busy,
    input wire logic                 read_blocked,
    input wire logic                 request_refused,
    input wire logic                 freq_out_of_range,
    input wire logic [15:0]          flash_clock_khz
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    wire logic req = program_request || erase_request;
////////////////////////////////////////
    chk_reset_locks: assert property (
        disable iff (1'b0) reset |=> !unlocked && !busy) else $error("not locked after reset");
    chk_locked_no_op: assert property (
        !unlocked && !busy && req |=> !flash_program && !flash_erase && request_refused)
        else $error("request taken while locked");
    chk_page_relocks: assert property (
        unlocked && page_write && !ctrl_write |=> !unlocked)
        else $error("page write kept lock open");
    chk_ctrl_relocks: assert property (
        unlocked && ctrl_write |=> !unlocked) else $error("control write kept lock open");
    chk_open_after_ctrl: assert property (
        $rose(unlocked) |-> $past(ctrl_write)) else $error("opened without key write");
    chk_wp_refuses: assert property (
        write_protect_option && !busy && req |=> request_refused && !flash_program && !flash_erase)
        else $error("write protect ignored");
    chk_sector_guard: assert property (
        $rose(flash_program) || $rose(flash_erase)
        |-> !sector_protect[flash_page[PAGE_BITS-1 -: 3]])
        else $error("protected sector altered");
    chk_read_guard: assert property (
        read_protect_option && debug_read_request && !cpu_read_request
        |=> read_blocked && !flash_read)
        else $error("protected read granted");
    chk_freq_high: assert property (
        freq_high_write |=> flash_clock_khz[15:8] == $past(write_data))
        else $error("high byte lost");
    chk_range_refuses: assert property (
        freq_out_of_range && !busy && req |=> request_refused) else $error("bad clock accepted");
    chk_op_holds: assert property (
        $rose(busy) |-> busy[*8]) else $error("operation ended early");
    chk_busy_drives: assert property (
        busy |-> flash_program || flash_erase) else $error("busy without array operation");
    cover property ($rose(unlocked));
    cover property ($rose(flash_erase));
    cover property (read_blocked);
    cover property (request_refused);
endmodule : fluntp_props
bind fluntp_top fluntp_props #(.PAGE_BITS(PAGE_BITS)) u_fluntp_props
(
    .clock, .reset, .ctrl_write, .page_write, .freq_high_write, .write_data, .sector_protect,
    .write_protect_option, .read_protect_option, .program_request, .erase_request,
    .debug_read_request, .cpu_read_request, .flash_program, .flash_erase, .flash_page,
    .flash_read, .unlocked, .busy, .read_blocked, .request_refused, .freq_out_of_range,
    .flash_clock_khz
);

/* File: tb/test_flash_unlock_timing_protect.sv */
`timescale 1ns/1ps
`include "fluntp_regs.svh"
module test_flash_unlock_timing_protect;
    logic        clock;
    logic        reset;
    logic [8:0]  strb;
    logic [7:0]  write_data;
    logic [7:0]  sector_protect;
    logic        write_protect_option;
    logic        read_protect_option;
    logic        flash_program;
    logic        flash_erase;
    logic        flash_read;
    logic        unlocked;
    logic        busy;
    logic        read_blocked;
    logic        request_refused;
    logic        freq_out_of_range;
    logic [6:0]  flash_page;
    logic [6:0]  last_page;
    logic [15:0] flash_clock_khz;
    logic [7:0]  writes;
    logic        seen_ref;
    logic        seen_blk;
    logic        seen_rd;
    int          bad_count;
    int          compares;
    logic [15:0] fv [4] = '{16'h0013, 16'h4e21, 16'h4e20, 16'h0014};
    logic        fo [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
    fluntp_top #(.OP_TICKS(16'h0001)) u_fluntp_top
    (
        .clock, .reset, .ctrl_write(strb[0]), .page_write(strb[1]),
        .freq_high_write(strb[2]), .freq_low_write(strb[3]), .write_data, .sector_protect,
        .write_protect_option, .read_protect_option, .program_request(strb[4]),
        .erase_request(strb[5]), .debug_read_request(strb[6]), .bypass_read_request(strb[7]),
        .cpu_read_request(strb[8]), .flash_program, .flash_erase, .flash_page, .flash_read,
        .unlocked, .busy, .read_blocked, .request_refused, .freq_out_of_range, .flash_clock_khz
    );
    fluntp_flash_model u_fluntp_flash_model
    (
        .clock, .flash_program, .flash_erase, .flash_page, .writes, .last_page
    );
////////////////////////////////////////
    initial
    begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    // Sticky record of one-cycle status pulses
    always @(posedge clock)
    begin
        if (request_refused) seen_ref <= 1'b1;
        if (read_blocked) seen_blk <= 1'b1;
        if (flash_read) seen_rd <= 1'b1;
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // Pulses strobe k for one cycle, then waits out any operation
    task automatic hit(input int k, input logic [7:0] d);
        int i;
        @(negedge clock);
        {seen_ref, seen_blk, seen_rd} = 3'b000;
        strb[k] = 1'b1;
        write_data = d;
        @(negedge clock);
        strb = 9'h000;
        for (i = 0; i < 300 && (i < 2 || busy !== 1'b0); i++)
            @(negedge clock);
    endtask : hit
    task automatic unlock(input logic [7:0] p);
        hit(0, `FLUNTP_CTRL_RESET_VAL);
        hit(1, p);
        hit(0, `FLUNTP_KEY1_DEFAULT);
        hit(0, `FLUNTP_KEY2_DEFAULT);
    endtask : unlock
    task automatic freq(input logic [15:0] v);
        hit(2, v[15:8]);
        hit(3, v[7:0]);
    endtask : freq
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : test_done
    // Whole run needs a few hundred cycles
    initial
    begin
        #400000;
        bad_count++;
        test_done();
    end
    initial
    begin
        {reset, strb, write_data, sector_protect} = {1'b1, 9'h000, 8'h00, 8'h00};
        {write_protect_option, read_protect_option} = 2'b00;
        {bad_count, compares} = 0;
        repeat (16) @(negedge clock);
        reset = 1'b0;
        chk({unlocked, busy, freq_out_of_range}, 3'b001);
        hit(4, 8'h00);
        chk({seen_ref, writes}, 9'h100);
        $display("locked test done");
        for (int i = 0; i < 4; i++)
        begin
            freq(fv[i]);
            chk(flash_clock_khz, fv[i]);
            chk(freq_out_of_range, fo[i]);
        end
        $display("frequency test done");
        unlock(8'h25);
        chk(unlocked, 1'b1);
        freq(16'h4e21);
        hit(4, 8'h00);
        chk({seen_ref, writes}, 9'h100);
        freq(16'h0014);
        hit(4, 8'h00);
        chk({last_page, writes}, {7'h25, 8'h01});
        hit(5, 8'h00);
        chk({unlocked, writes}, 9'h102);
        sector_protect = 8'h04;
        hit(5, 8'h00);
        chk(seen_ref, 1'b1);
        {sector_protect, write_protect_option} = {8'hfb, 1'b1};
        hit(4, 8'h00);
        chk({seen_ref, writes}, 9'h102);
        write_protect_option = 1'b0;
        hit(4, 8'h00);
        chk(writes, 8'h03);
        sector_protect = 8'h00;
        $display("program test done");
        hit(1, 8'h25);
        hit(4, 8'h00);
        chk({unlocked, writes}, 9'h003);
        hit(0, 8'h00);
        hit(1, 8'h25);
        hit(0, 8'h55);
        hit(0, `FLUNTP_KEY2_DEFAULT);
        chk(unlocked, 1'b0);
        hit(1, 8'h25);
        hit(0, `FLUNTP_KEY1_DEFAULT);
        hit(0, `FLUNTP_KEY2_DEFAULT);
        chk(unlocked, 1'b0);
        $display("relock test done");
        read_protect_option = 1'b1;
        for (int k = 6; k < 9; k++)
        begin
            hit(k, 8'h00);
            chk({seen_blk, seen_rd}, {k < 8, k == 8});
        end
        read_protect_option = 1'b0;
        hit(6, 8'h00);
        chk({seen_blk, seen_rd}, 2'b01);
        $display("read test done");
        unlock(8'h10);
        chk(unlocked, 1'b1);
        reset = 1'b1;
        @(negedge clock);
        reset = 1'b0;
        chk({unlocked, freq_out_of_range}, 2'b01);
        $display("reset test done");
        test_done();
    end
endmodule : test_flash_unlock_timing_protect
